/* prot_pkg.sv */
// Constants shared by the servo protection threshold logic
package prot_pkg;

  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;        // System clock period
  localparam int unsigned TICK_TIME_NS  = 2_000_000; // Control period, 2 ms
  localparam int unsigned TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Regenerative resistor selection codes
  // ---------------------------------------------------------------
  localparam logic [1:0] REGEN_BUILTIN  = 2'h0;      // Built-in resistor, about 1 % duty
  localparam logic [1:0] REGEN_EXT_PROT = 2'h1;      // External, trip above 10 %
  localparam logic [1:0] REGEN_EXT_FREE = 2'h2;      // External, no overload trip
  localparam logic [1:0] REGEN_NONE     = 2'h3;      // No resistor on small frames
  localparam logic [1:0] REGEN_RESET    = 2'h0;      // Selection before first load

  // Regenerative duty window and limits in percent
  localparam logic [7:0]  REGEN_WIN_TICKS  = 8'h32;  // 50 control periods
  localparam logic [7:0]  REGEN_EXT_PCT    = 8'h0A;  // 10 %
  localparam logic [7:0]  REGEN_BUILT_PCT  = 8'h01;  // 1 %
  localparam logic [15:0] PCT_FULL         = 16'h0064; // 100 %

  // ---------------------------------------------------------------
  // Main power-off detection, in 2 ms units
  // ---------------------------------------------------------------
  localparam logic [9:0] MAINS_TIME_MIN     = 10'h023; // 35
  localparam logic [9:0] MAINS_TIME_DISABLE = 10'h3E8; // 1000
  localparam logic [9:0] MAINS_TIME_RESET   = 10'h023; // Default 35

  // ---------------------------------------------------------------
  // Deceleration selections that use the emergency-stop torque
  // ---------------------------------------------------------------
  localparam logic [3:0] DECEL_SEL_A = 4'h8;
  localparam logic [3:0] DECEL_SEL_B = 4'h9;

  // ---------------------------------------------------------------
  // Protective levels
  // ---------------------------------------------------------------
  localparam logic [8:0]  TORQUE_MAX_PCT   = 9'h1F4;  // 500 %
  localparam logic [8:0]  OVERLOAD_CAP_PCT = 9'h073;  // 115 %
  localparam int unsigned DEV_UNIT_SHIFT   = 8;       // Level unit is 256 pulses
  localparam logic [14:0] DEV_LEVEL_DEF    = 15'h61A8; // 25000
  localparam logic [2:0]  SPEED_CAP_NUM    = 3'h6;    // 1.2 = 6 / 5
  localparam logic [2:0]  SPEED_CAP_DEN    = 3'h5;

  // ---------------------------------------------------------------
  // Error flag positions
  // ---------------------------------------------------------------
  localparam int unsigned NUM_FLAGS     = 5;
  localparam int unsigned FLAG_REGEN    = 0;
  localparam int unsigned FLAG_DEV      = 1;
  localparam int unsigned FLAG_OVERLOAD = 2;
  localparam int unsigned FLAG_OVERSPD  = 3;
  localparam int unsigned FLAG_MAINS    = 4;

endpackage : prot_pkg

/* ctrl_tick.sv */
// Control-period tick generator
`timescale 1ns/1ps
module ctrl_tick #(
  parameter int unsigned CYCLES = 50000   // Clock cycles per control period
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      tick
);

  initial begin
    if (CYCLES < 2) $error("ctrl_tick: CYCLES must be at least 2");
  end

  localparam int unsigned CW = $clog2(CYCLES);

  logic [CW-1:0] cnt_r;   // Cycles elapsed in this period

  // ---------------------------------------------------------------
  // Free-running period counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(CYCLES - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Tick in the last cycle of each period
  assign tick = (cnt_r == CW'(CYCLES - 1));

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Ticks are one cycle wide and never adjacent
  a_tick_single : assert property (tick |=> !tick)
    else $error("tick lasted more than one cycle");

endmodule : ctrl_tick

/* trip_latch.sv */
// Sticky trip flag with set priority over clear
`timescale 1ns/1ps
module trip_latch (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_r
);

  // ---------------------------------------------------------------
  // Flag holds until cleared; a set in the clear cycle wins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr) begin
      flag_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_latch_sticky : assert property (flag_r && !clr |=> flag_r)
    else $error("trip flag dropped without a clear");
  a_latch_setwin : assert property (set |=> flag_r)
    else $error("trip flag not set after trip");

endmodule : trip_latch

/* servo_protection_thresholds.sv */
// Protective supervision thresholds of the servo drive
`timescale 1ns/1ps
module servo_protection_thresholds
  import prot_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,  // Clock cycles per 2 ms period
  parameter int unsigned DEV_W    = 32,           // Deviation magnitude width
  parameter int unsigned SPD_W    = 16            // Speed width in r/min
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,                      // Power-on reset
  // Parameters
  input  wire logic [1:0]       regen_resistor_select,    // Loaded at power-on only
  input  wire logic [9:0]       mains_off_detect_time,    // Loaded at power-on only
  input  wire logic [8:0]       estop_torque_limit,       // Percent
  input  wire logic [3:0]       mains_off_error_response,
  input  wire logic [3:0]       servo_off_sequence,
  input  wire logic [14:0]      deviation_error_level,    // 256-pulse units
  input  wire logic [8:0]       overload_level,           // Percent
  input  wire logic [14:0]      overspeed_level,          // r/min
  // Plant state
  input  wire logic             small_frame,              // Drive has no built-in resistor
  input  wire logic             mains_present_pin,        // Main power sense, asynchronous
  input  wire logic             regen_active,             // Regen switch on this cycle
  input  wire logic             decel_mains_off,          // Decelerating after mains off
  input  wire logic             decel_servo_off,          // Decelerating after servo off
  input  wire logic [8:0]       normal_torque_limit,      // Percent
  input  wire logic             full_closed,              // Full-closed control mode
  input  wire logic [DEV_W-1:0] encoder_deviation,        // Encoder pulses, magnitude
  input  wire logic [DEV_W-1:0] scale_deviation,          // Scale pulses, magnitude
  input  wire logic [8:0]       load_pct,                 // Load, percent of rating
  input  wire logic [SPD_W-1:0] motor_speed,              // Magnitude, r/min
  input  wire logic [SPD_W-1:0] motor_max_speed,          // r/min
  input  wire logic             error_clear,              // Clears all trip flags
  // Results
  output logic                  regen_circuit_en,
  output logic [8:0]            torque_limit,
  output logic                  mains_lost,
  output logic                  regen_overload_error,
  output logic                  deviation_excess_error,
  output logic                  overload_error,
  output logic                  overspeed_error
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (DEV_W < 24) $error("DEV_W too narrow for the deviation level");
    if (SPD_W < 15) $error("SPD_W too narrow for the over-speed level");
  end

  // ---------------------------------------------------------------
  // Control period tick
  // ---------------------------------------------------------------
  logic tick;                      // One cycle every 2 ms

  ctrl_tick #(.CYCLES(TICK_CYC)) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick)
  );

  // ---------------------------------------------------------------
  // Mains sense synchroniser
  // ---------------------------------------------------------------
  logic mains_s1_r;                // First stage, read only by second
  logic mains_s2_r;                // Safe level

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mains_s1_r <= 1'b1;
      mains_s2_r <= 1'b1;
    end else begin
      mains_s1_r <= mains_present_pin;
      mains_s2_r <= mains_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Power-cycle parameters, captured once after reset release
  // ---------------------------------------------------------------
  logic       cfg_loaded_r;        // Power-on capture done
  logic [1:0] regen_sel_r;         // Frozen resistor selection
  logic [9:0] mains_time_r;        // Frozen detection time

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_loaded_r <= 1'b0;
      regen_sel_r  <= REGEN_RESET;
      mains_time_r <= MAINS_TIME_RESET;
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r <= 1'b1;
      regen_sel_r  <= regen_resistor_select;
      // Below the range the shortest time is used
      mains_time_r <= (mains_off_detect_time < MAINS_TIME_MIN) ?
                      MAINS_TIME_MIN : mains_off_detect_time;
    end
  end

  // ---------------------------------------------------------------
  // Regenerative circuit enable and duty monitor
  // ---------------------------------------------------------------
  logic       regen_none;          // Resistor-less small frame
  logic [7:0] regen_win_r;         // Periods elapsed in window
  logic [7:0] regen_on_r;          // Periods with regen active
  logic [7:0] regen_pct;           // Allowed duty for this selection
  logic       regen_prot;          // Overload protection active
  logic       regen_trip;          // Duty over the allowed ratio

  assign regen_none       = (regen_sel_r == REGEN_NONE) && small_frame;
  assign regen_circuit_en = cfg_loaded_r && !regen_none;

  // Protection only for built-in and protected external resistor
  always_comb begin
    regen_prot = 1'b0;
    regen_pct  = REGEN_BUILT_PCT;
    if (regen_sel_r == REGEN_EXT_PROT) begin
      regen_prot = 1'b1;
      regen_pct  = REGEN_EXT_PCT;
    end else if (regen_sel_r == REGEN_BUILTIN) begin
      regen_prot = 1'b1;
    end
    // Selection 2 regenerates freely; selection 3 has no circuit on small frames
  end

  // Sample duty once per period over a fixed window
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regen_win_r <= '0;
      regen_on_r  <= '0;
    end else if (tick) begin
      if (regen_win_r == REGEN_WIN_TICKS - 8'h01) begin
        regen_win_r <= '0;
        regen_on_r  <= '0;
      end else begin
        regen_win_r <= regen_win_r + 8'h01;
        regen_on_r  <= regen_on_r + 8'(regen_active && regen_circuit_en);
      end
    end
  end

  // Ratio in percent compared without division
  assign regen_trip = tick && regen_prot && regen_circuit_en &&
                      (regen_win_r == REGEN_WIN_TICKS - 8'h01) &&
                      (16'(regen_on_r) * PCT_FULL >
                       16'(regen_pct) * 16'(REGEN_WIN_TICKS));

  // ---------------------------------------------------------------
  // Main power-off detection
  // ---------------------------------------------------------------
  logic [9:0] mains_off_cnt_r;     // Periods of continuous mains off
  logic       mains_trip;          // Off time reached

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mains_off_cnt_r <= '0;
    end else if (mains_s2_r) begin
      mains_off_cnt_r <= '0;
    end else if (tick && mains_off_cnt_r != MAINS_TIME_DISABLE) begin
      mains_off_cnt_r <= mains_off_cnt_r + 10'h001;
    end
  end

  assign mains_trip = tick && cfg_loaded_r && !mains_s2_r &&
                      (mains_time_r != MAINS_TIME_DISABLE) &&
                      (mains_off_cnt_r >= mains_time_r);

  // ---------------------------------------------------------------
  // Emergency-stop torque limit; the stop input plays no part
  // ---------------------------------------------------------------
  logic estop_decel;               // Selected deceleration sequence
  logic [8:0] estop_clip;          // Stop torque within range

  assign estop_decel =
    (decel_mains_off && (mains_off_error_response == DECEL_SEL_A ||
                         mains_off_error_response == DECEL_SEL_B)) ||
    (decel_servo_off && (servo_off_sequence == DECEL_SEL_A ||
                         servo_off_sequence == DECEL_SEL_B));
  assign estop_clip = (estop_torque_limit > TORQUE_MAX_PCT) ?
                      TORQUE_MAX_PCT : estop_torque_limit;

  // Registered limit output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      torque_limit <= '0;
    end else if (estop_decel && estop_clip != '0) begin
      torque_limit <= estop_clip;
    end else begin
      torque_limit <= normal_torque_limit;
    end
  end

  // ---------------------------------------------------------------
  // Position deviation excess
  // ---------------------------------------------------------------
  logic [DEV_W-1:0] dev_sel;       // Deviation in the active unit
  logic [DEV_W-1:0] dev_limit;     // Level in pulses
  logic             dev_trip;

  assign dev_sel   = full_closed ? scale_deviation : encoder_deviation;
  assign dev_limit = DEV_W'(deviation_error_level) << DEV_UNIT_SHIFT;
  assign dev_trip  = tick && (deviation_error_level != '0) &&
                     (dev_sel > dev_limit);

  // ---------------------------------------------------------------
  // Overload level
  // ---------------------------------------------------------------
  logic [8:0] ovl_eff;             // Effective overload level
  logic       ovl_trip;

  assign ovl_eff  = (overload_level == '0 || overload_level > OVERLOAD_CAP_PCT) ?
                    OVERLOAD_CAP_PCT : overload_level;
  assign ovl_trip = tick && (load_pct > ovl_eff);

  // ---------------------------------------------------------------
  // Over-speed level; exact r/min compare keeps well inside tolerance
  // ---------------------------------------------------------------
  logic [SPD_W+2:0] spd_cap;       // 1.2 times maximum speed
  logic [SPD_W+2:0] spd_eff;       // Effective over-speed level
  logic             ovs_trip;

  // Widened before the product so that a fast motor cannot overflow the cap
  assign spd_cap  = ((SPD_W+3)'(motor_max_speed) * (SPD_W+3)'(SPEED_CAP_NUM)) /
                    (SPD_W+3)'(SPEED_CAP_DEN);
  assign spd_eff  = (overspeed_level == '0 || (SPD_W+3)'(overspeed_level) > spd_cap) ?
                    spd_cap : (SPD_W+3)'(overspeed_level);
  assign ovs_trip = tick && ((SPD_W+3)'(motor_speed) > spd_eff);

  // ---------------------------------------------------------------
  // Sticky error flags
  // ---------------------------------------------------------------
  logic [NUM_FLAGS-1:0] trip_set;  // Per-flag trip events
  logic [NUM_FLAGS-1:0] flag_q;    // Latched flags

  always_comb begin
    trip_set                = '0;
    trip_set[FLAG_REGEN]    = regen_trip;
    trip_set[FLAG_DEV]      = dev_trip;
    trip_set[FLAG_OVERLOAD] = ovl_trip;
    trip_set[FLAG_OVERSPD]  = ovs_trip;
    trip_set[FLAG_MAINS]    = mains_trip;
  end

  // One latch per error, evaluated each control period
  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    trip_latch u_latch (
      .clk_sys (clk_sys),
      .rst     (rst),
      .set     (trip_set[i]),
      .clr     (error_clear),
      .flag_r  (flag_q[i])
    );
  end

  assign regen_overload_error   = flag_q[FLAG_REGEN];
  assign deviation_excess_error = flag_q[FLAG_DEV];
  assign overload_error         = flag_q[FLAG_OVERLOAD];
  assign overspeed_error        = flag_q[FLAG_OVERSPD];
  assign mains_lost             = flag_q[FLAG_MAINS];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_mains_rise;
    !mains_lost ##1 mains_lost;
  endsequence

  a_regen_small_off : assert property (regen_none |-> !regen_circuit_en && !regen_trip)
    else $error("regen active on resistor-less frame");
  a_regen_free_sel : assert property (regen_sel_r == REGEN_EXT_FREE |-> !regen_trip)
    else $error("regen trip with unprotected selection");
  a_mains_off_time : assert property (s_mains_rise |-> !$past(mains_s2_r) &&
                                      $past(mains_off_cnt_r) >= $past(mains_time_r))
    else $error("mains lost before off time elapsed");
  a_mains_disabled : assert property (mains_time_r == MAINS_TIME_DISABLE |-> !mains_trip)
    else $error("mains detection not disabled");
  a_estop_torque : assert property (estop_decel && estop_clip != '0 |=>
                                    torque_limit == $past(estop_clip))
    else $error("stop torque not applied");
  a_normal_torque : assert property (!estop_decel |=>
                                     torque_limit == $past(normal_torque_limit))
    else $error("normal torque not applied");
  a_dev_trip_lvl : assert property (tick && deviation_error_level != '0 &&
                                    dev_sel > dev_limit |=> deviation_excess_error)
    else $error("deviation excess not flagged");
  a_dev_level_off : assert property (deviation_error_level == '0 |-> !dev_trip)
    else $error("deviation trip while disabled");
  a_ovl_cap : assert property (ovl_eff <= OVERLOAD_CAP_PCT && ovl_eff != '0)
    else $error("overload level out of range");
  a_ovs_cap : assert property (spd_eff <= spd_cap)
    else $error("over-speed level above cap");
  a_cfg_frozen : assert property (cfg_loaded_r |=> $stable(regen_sel_r) &&
                                  $stable(mains_time_r))
    else $error("power-cycle parameter changed after load");
  a_trip_on_tick : assert property (|trip_set |-> tick)
    else $error("trip outside control period");

endmodule : servo_protection_thresholds

/* plant_model.sv */
// Motor, encoder and power stage model facing the protection block
`timescale 1ns/1ps
module plant_model (
  input  wire logic        clk_sys,
  input  wire logic        m_c,                // Mains wanted on
  input  wire logic        r_c,                // Regen switch wanted on
  input  wire logic [31:0] e_c,                // Encoder deviation wanted
  input  wire logic [31:0] s_c,                // Scale deviation wanted
  input  wire logic [8:0]  l_c,                // Load wanted
  input  wire logic [15:0] v_c,                // Speed wanted
  output logic             mains_present_pin,
  output logic             regen_active,
  output logic [31:0]      encoder_deviation,
  output logic [31:0]      scale_deviation,
  output logic [8:0]       load_pct,
  output logic [15:0]      motor_speed
);
  // Plant quantities move just after the rising edge
  always @(posedge clk_sys) begin
    mains_present_pin <= m_c;
    regen_active      <= r_c;
    encoder_deviation <= e_c;
    scale_deviation   <= s_c;
    load_pct          <= l_c;
    motor_speed       <= v_c;
  end
endmodule : plant_model

/* tb_servo_protection_thresholds.sv */
// Self-checking bench for the protection thresholds
`timescale 1ns/1ps
module tb_servo_protection_thresholds;
  import prot_pkg::*;
  localparam int unsigned TC = 20;  // Short control period
  logic clk_sys = 1'b0, rst = 1'b1, error_clear = 1'b0, small_frame = 1'b0;
  logic decel_mains_off = 1'b0, decel_servo_off = 1'b0, full_closed = 1'b0;
  logic m_c = 1'b1, r_c = 1'b0;
  logic [1:0] regen_resistor_select = 2'h1;
  logic [9:0] mains_off_detect_time = 10'h023;
  logic [8:0] estop_torque_limit = 9'h000, overload_level = 9'h000;
  logic [8:0] normal_torque_limit = 9'h064, l_c = 9'h000, load_pct, torque_limit;
  logic [3:0] mains_off_error_response = 4'h0, servo_off_sequence = 4'h0;
  logic [14:0] deviation_error_level = 15'h0000, overspeed_level = 15'h0000;
  logic [31:0] e_c = 32'h0, s_c = 32'h0, encoder_deviation, scale_deviation;
  logic [15:0] v_c = 16'h0, motor_max_speed = 16'h03E8, motor_speed;
  logic mains_present_pin, regen_active, regen_circuit_en, mains_lost;
  logic regen_overload_error, deviation_excess_error, overload_error, overspeed_error;
  int num_errors = 0, checks_done = 0, seed = 9851;
  logic [4:0] prev_f = 5'h00, q[$];
  logic [53:0] tbl[10] = '{{9'h000, 9'h074, 15'h0, 16'h0, 5'h02},
    {9'h000, 9'h073, 15'h0, 16'h0, 5'h00}, {9'h0C8, 9'h074, 15'h0, 16'h0, 5'h02},
    {9'h064, 9'h065, 15'h0, 16'h0, 5'h02}, {9'h064, 9'h064, 15'h0, 16'h0, 5'h00},
    {9'h000, 9'h000, 15'h0, 16'h04B1, 5'h01}, {9'h000, 9'h000, 15'h0, 16'h04B0, 5'h00},
    {9'h000, 9'h000, 15'h05DC, 16'h04B1, 5'h01},
    {9'h000, 9'h000, 15'h01F4, 16'h01F5, 5'h01},
    {9'h000, 9'h000, 15'h01F4, 16'h01F4, 5'h00}};
  wire [4:0] flags = {mains_lost, regen_overload_error, deviation_excess_error,
                      overload_error, overspeed_error};

  plant_model pm_u (.clk_sys, .m_c, .r_c, .e_c, .s_c, .l_c, .v_c, .mains_present_pin,
    .regen_active, .encoder_deviation, .scale_deviation, .load_pct, .motor_speed);
  servo_protection_thresholds #(.TICK_CYC(TC)) dut_u (.clk_sys, .rst,
    .regen_resistor_select, .mains_off_detect_time, .estop_torque_limit,
    .mains_off_error_response, .servo_off_sequence, .deviation_error_level,
    .overload_level, .overspeed_level, .small_frame, .mains_present_pin, .regen_active,
    .decel_mains_off, .decel_servo_off, .normal_torque_limit, .full_closed,
    .encoder_deviation, .scale_deviation, .load_pct, .motor_speed, .motor_max_speed,
    .error_clear, .regen_circuit_en, .torque_limit, .mains_lost, .regen_overload_error,
    .deviation_excess_error, .overload_error, .overspeed_error);

  always #20 clk_sys = ~clk_sys;

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Note the expected trip (or none), wait for it, calm the plant, clear the flags
  task automatic step(input logic [4:0] f, input int n);
    if (f !== 5'h00) q.push_back(f);
    for (int i = 0; i < n && (f === 5'h00 || q.size() != 0); i++) @(negedge clk_sys);
    chk(9'(q.size()), 9'h000);
    q.delete();
    {m_c, r_c, e_c, s_c, l_c, v_c} = {2'b10, 89'h0};
    @(negedge clk_sys);
    error_clear = 1'b1;
    repeat (4) @(negedge clk_sys);
    error_clear = 1'b0;
  endtask : step

  // Any new trip takes the oldest note; a trip with no note is a mismatch
  always @(negedge clk_sys) begin
    if (!rst && flags !== prev_f && flags !== 5'h00)
      chk(9'(flags), (q.size() != 0) ? 9'(q.pop_front()) : 9'h000);
    prev_f <= flags;
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    regen_resistor_select = 2'h3;  // Written after power-on, so ignored
    estop_torque_limit = 9'h12C;
    for (int i = 0; i < 32; i++) begin
      normal_torque_limit = 9'($unsigned($random(seed)) % 500);
      mains_off_error_response = i[3:0];
      servo_off_sequence = i[3:0];
      decel_mains_off = !i[4];
      decel_servo_off = i[4];
      repeat (2) @(negedge clk_sys);
      chk(torque_limit, (i[3:1] == 3'h4) ? 9'h12C : normal_torque_limit);
    end
    decel_servo_off = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(torque_limit, normal_torque_limit);
    {decel_mains_off, mains_off_error_response, estop_torque_limit} = {5'h19, 9'h000};
    repeat (2) @(negedge clk_sys);
    chk(torque_limit, normal_torque_limit);
    estop_torque_limit = 9'h1FF;
    repeat (2) @(negedge clk_sys);
    chk(torque_limit, 9'h1F4);
    decel_mains_off = 1'b0;
    deviation_error_level = 15'h0001;
    e_c = 32'h101;
    step(5'h04, 4 * TC);
    e_c = 32'h100;
    step(5'h00, 3 * TC);
    full_closed = 1'b1;
    e_c = 32'h101 + ($unsigned($random(seed)) & 32'hFFFF);
    s_c = 32'h100;
    step(5'h00, 3 * TC);
    s_c = 32'h101;
    step(5'h04, 4 * TC);
    deviation_error_level = 15'h0000;
    s_c = 32'hFFFFFFFF;
    step(5'h00, 3 * TC);
    for (int i = 0; i < 10; i++) begin
      {overload_level, l_c, overspeed_level, v_c} = tbl[i][53:5];
      step(tbl[i][4:0], 4 * TC);
    end
    m_c = 1'b0;
    repeat (30 * TC) @(negedge clk_sys);
    m_c = 1'b1;
    repeat (TC + 4) @(negedge clk_sys);
    m_c = 1'b0;
    repeat (34 * TC) @(negedge clk_sys);
    chk({8'h00, mains_lost}, 9'h000);
    step(5'h10, 4 * TC);
    chk({8'h00, regen_circuit_en}, 9'h001);
    r_c = 1'b1;
    step(5'h08, 110 * TC);
    // Power cycles: resistor-less small frame, free selection with mains
    // detection off and mains gone, then the built-in resistor
    for (int k = 0; k < 3; k++) begin
      rst = 1'b1;
      small_frame = (k == 0);
      regen_resistor_select = (k == 2) ? 2'h0 : 2'(3 - k);
      mains_off_detect_time = (k == 1) ? 10'h3E8 : 10'h023;
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk({8'h00, regen_circuit_en}, {8'h00, k != 0});
      {m_c, r_c} = {k != 1, 1'b1};
      step((k == 2) ? 5'h08 : 5'h00, 110 * TC);
    end
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
endmodule : tb_servo_protection_thresholds
